/* bench/icv_convolver_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Self-checking bench of the convolver: only tap A carries a coefficient.
// ---------------------------------------------------------------------------
module icv_convolver_top_tb;
  import icv_pkg::*;

  logic              clk, rst, frame_n, hold, oe_n;
  logic [7:0]        pixel_in;
  logic [15:0]       cascade_in;
  logic              cs_n, load_strobe_n, operand_load_en, result_oe_n;
  logic [2:0]        reg_select;
  logic [9:0]        config_bus;
  logic [19:0]       result_out;
  logic [7:0]        cascade_out;
  int                err_total, comparisons;
  logic [8:0]        ini [11] = '{9'h000, 9'h008, 9'h010, 9'h018, 9'h020, 9'h040,
                                  9'h060, 9'h080, 9'h100, 9'h180, 9'h001};
  logic [19:0]       ini_exp [11] = '{20'h0fd03, 20'hfff03, 20'hffe03, 20'h00003,
                                      20'h0fd00, 20'h10000, 20'h0fd03, 20'h0fd06,
                                      20'h0fd12, 20'h0fd42, 20'h0fd02};
  logic [9:0]        mc [16] = '{10'h018, 10'h028, 10'h031, 10'h04a, 10'h04c, 10'h000,
                                 10'h078, 10'h030, 10'h008, 10'h060, 10'h218, 10'h278,
                                 10'h098, 10'h318, 10'h398, 10'h031};
  logic [19:0]       mc_exp [16] = '{20'h0f, 20'h06, 20'h15, 20'h09, 20'h2f7, 20'h0,
                                     20'h2fd, 20'h15, 20'h0, 20'h2ee, 20'h1e, 20'h2fa,
                                     20'h06, 20'h78, 20'h0f, 20'h15};

  icv_convolver_top icv_convolver_top_i (
    .clk(clk), .rst(rst), .frame_n(frame_n), .hold(hold), .pixel_in(pixel_in),
    .config_bus(config_bus), .reg_select(reg_select), .cs_n(cs_n),
    .load_strobe_n(load_strobe_n), .operand_load_en(operand_load_en),
    .cascade_in(cascade_in), .oe_n(oe_n), .result_out(result_out),
    .result_oe_n(result_oe_n), .cascade_out(cascade_out)
  );

  icv_host_model host_i (
    .clk(clk), .cs_n(cs_n), .load_strobe_n(load_strobe_n), .reg_select(reg_select),
    .config_bus(config_bus), .operand_load_en(operand_load_en)
  );

  // Free-running clock at 50 MHz.
  always #10 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Comparison, timing helpers and the single closing point.
  // ---------------------------------------------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [19:0] pick(input logic cas);
    return cas ? {12'h0, cascade_out} : result_out;
  endfunction

  // Long enough for the deepest path used here, so the output is steady.
  task automatic settle(input logic [7:0] p);
    @(negedge clk);
    pixel_in = p;
    repeat (20) @(negedge clk);
  endtask

  // Steps the pixel after a steady run and checks the exact edge it lands on.
  task automatic lat(input logic [7:0] p0, input logic [7:0] p1, input int n,
                     input logic cas, input logic [19:0] e0, input logic [19:0] e1);
    settle(p0);
    pixel_in = p1;
    repeat (n) @(posedge clk);
    @(negedge clk);
    check(pick(cas), e0);
    @(negedge clk);
    check(pick(cas), e1);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Test sequence.
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    frame_n = 1'b1;
    hold = 1'b0;
    oe_n = 1'b0;
    pixel_in = '0;
    cascade_in = '0;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(negedge clk);
    check(result_out, '0);
    check(pick(1'b1), '0);
    rst = 1'b0;
    $display("test reset done");
    host_i.load(ADDR_ROWLEN, 10'h004, 1'b0);
    host_i.kernel(ADDR_BANK0, 8'h03);
    lat(8'h05, 8'h08, 4, 1'b0, 20'h0f, 20'h18);
    lat(8'h08, 8'h05, 9, 1'b1, 20'h08, 20'h05);
    // A second row length write must be refused until the next reset.
    host_i.load(ADDR_ROWLEN, 10'h002, 1'b0);
    lat(8'h08, 8'h05, 9, 1'b1, 20'h08, 20'h05);
    host_i.load(ADDR_INIT, 10'h006, 1'b0);
    lat(8'h05, 8'h08, 7, 1'b0, 20'h0f, 20'h18);
    $display("test latency done");
    // The idle bank is rewritten while bank zero keeps filtering.
    host_i.kernel(ADDR_BANK1, 8'hfe);
    settle(8'h05);
    check(result_out, 20'h0f);
    host_i.load(ADDR_USE1, '0, 1'b0);
    settle(8'h05);
    check(result_out, 20'h4f6);
    cascade_in = 16'h0001;
    foreach (ini[k]) begin
      host_i.load(ADDR_INIT, {1'b0, ini[k]}, 1'b0);
      settle(8'hff);
      check(result_out, ini_exp[k]);
    end
    $display("test formats done");
    cascade_in = '0;
    host_i.load(ADDR_INIT, '0, 1'b0);
    host_i.load(ADDR_USE0, '0, 1'b0);
    host_i.operand(8'h02);
    foreach (mc[k]) begin
      host_i.load(ADDR_MICRO, mc[k], 1'b0);
      settle(8'h05);
      check(result_out, mc_exp[k]);
    end
    $display("test point ops done");
    host_i.load(ADDR_MICRO, 10'h000, 1'b1);
    host_i.load(3'h7, 10'h000, 1'b0);
    settle(8'h05);
    check(result_out, 20'h15);
    hold = 1'b1;
    pixel_in = 8'h09;
    repeat (8) @(negedge clk);
    check(result_out, 20'h15);
    hold = 1'b0;
    settle(8'h09);
    check(result_out, 20'h21);
    frame_n = 1'b0;
    repeat (2) @(negedge clk);
    check(result_out, '0);
    check(pick(1'b1), '0);
    frame_n = 1'b1;
    settle(8'h05);
    check(result_out, 20'h15);
    oe_n = 1'b1;
    #1 check({19'h0, result_oe_n}, 20'h1);
    @(negedge clk);
    oe_n = 1'b0;
    #1 check({19'h0, result_oe_n}, 20'h0);
    $display("test controls done");
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check(result_out, '0);
    check(pick(1'b1), '0);
    rst = 1'b0;
    $display("test second reset done");
    // Left unwritten, the row length locks at full depth and refuses late writes.
    repeat (1030) @(negedge clk);
    host_i.load(ADDR_ROWLEN, 10'h004, 1'b0);
    settle(8'h05);
    check(pick(1'b1), '0);
    $display("test row timeout done");
    complete_run();
  end
endmodule
`default_nettype wire

/* bench/icv_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Host side of the configuration port and the operand load.
// ---------------------------------------------------------------------------
module icv_host_model (
  input  wire logic                      clk,
  output logic                           cs_n,
  output logic                           load_strobe_n,
  output logic [2:0]                     reg_select,
  output logic [icv_pkg::CFG_W-1:0]      config_bus,
  output logic                           operand_load_en
);
  import icv_pkg::*;

  // Idle levels keep select and strobe high so nothing is loaded.
  initial begin
    cs_n = 1'b1;
    load_strobe_n = 1'b1;
    reg_select = 3'h7;
    config_bus = '0;
    operand_load_en = 1'b0;
  end

  // One strobed load; address and data stand until the edge that sees the strobe high.
  task automatic load(input logic [2:0] a, input logic [CFG_W-1:0] d, input logic sel_n);
    @(negedge clk);
    cs_n = sel_n;
    load_strobe_n = 1'b0;
    reg_select = a;
    config_bus = d;
    @(negedge clk);
    load_strobe_n = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
  endtask

  // Select and strobe stay idle, or a control register could be overwritten.
  task automatic operand(input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b1;
    config_bus = {2'h0, d};
    operand_load_en = 1'b1;
    @(negedge clk);
    operand_load_en = 1'b0;
  endtask

  // A kernel is nine loads in tap order: first tap given, the rest zero.
  task automatic kernel(input logic [2:0] a, input logic [7:0] c0);
    for (int i = 0; i < TAPS; i++) begin
      load(a, (i == 0) ? {2'h0, c0} : '0, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* design/icv_convolver_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Frame start clears pipeline, keeps configuration.
// - Pixels and coefficients each signed or unsigned.
// - Result is twenty bits wide.
// - Data registers on clock; controls on strobe.
// - Pixel delay line of one to four.
// - Config bus width depends on target register.
// - Cascade output is twice-row-delayed ALU output.
// - Reset zeroes all but strobe sample; microcode takes default.
// - Operand register loads when its enable high.
// - Sampled hold freezes data path from next edge; control loads continue.
// - Output enable low drives result bus.
// - Chip select high blocks control loads.
// - Strobe rise with select low loads register.
// - Microcode: top shift field, low operation.
// - ALU operands: delayed pixel and operand register.
// - Two series row buffers, 1 to 1024.
// - Setup bit zero picks internal or cascade rows.
// - Nine multipliers summed into one result.
// - Two kernels, exactly one active.
// - Address five/six activate bank zero/one.
// - Nine strobes fill a bank in order.
// - Row length once per reset, auto zero.
// - Setup fields: delay, formats, rounding, shift.
module icv_convolver_top (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        frame_n,
  input  wire logic                        hold,
  input  wire logic [icv_pkg::PIX_W-1:0]   pixel_in,
  input  wire logic [icv_pkg::CFG_W-1:0]   config_bus,
  input  wire logic [2:0]                  reg_select,
  input  wire logic                        cs_n,
  input  wire logic                        load_strobe_n,
  input  wire logic                        operand_load_en,
  input  wire logic [icv_pkg::CAS_W-1:0]   cascade_in,
  input  wire logic                        oe_n,
  output logic      [icv_pkg::RES_W-1:0]   result_out,
  output logic                             result_oe_n,
  output logic      [icv_pkg::PIX_W-1:0]   cascade_out
);
  import icv_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                                 ld_q;
    logic                                 hold_q;
    logic [CFG_W-1:0]                     micro;
    logic [CFG_W-1:0]                     row_len;
    icv_row_state_t                       row_state;
    logic [10:0]                          row_cnt;
    logic [INIT_W-1:0]                    init;
    logic [PIX_W-1:0]                     operand;
    logic                                 bank_sel;
    logic [3:0]                           wptr0;
    logic [3:0]                           wptr1;
    logic [TAPS-1:0][PIX_W-1:0]           coef0;
    logic [TAPS-1:0][PIX_W-1:0]           coef1;
    logic [DLY_MAX-1:0][PIX_W-1:0]        dly;
    logic [PIX_W-1:0]                     alu_q;
    logic [2:0][2:0][PIX_W-1:0]           win;
    logic [TAPS-1:0][PROD_W-1:0]          prod;
    logic [RES_W-1:0]                     result;
  } icv_state_t;

  icv_state_t       st;
  icv_state_t       next_st;
  logic             run;
  logic             strobe_rise;
  logic [PIX_W-1:0] alu_y;
  logic [PIX_W-1:0] row1_q;
  logic [PIX_W-1:0] row2_q;
  logic [PIX_W-1:0] src1;
  logic [PIX_W-1:0] src2;
  logic [1:0]       dly_sel;

  // The hold input is registered first, so it acts one edge late.
  assign run = !st.hold_q;

  // A load happens on the low-to-high step of the strobe while selected.
  assign strobe_rise = !st.ld_q && load_strobe_n && !cs_n;

  assign dly_sel = st.init[INIT_DLY_LO +: 2];

  // ---------------------------------------------------------------------------
  // Point operation and row buffers
  // ---------------------------------------------------------------------------
  icv_point_alu u_alu (
    .a     (st.dly[dly_sel]),
    .b     (st.operand),
    .op    (st.micro[MICRO_OP_W-1:0]),
    .shift (st.micro[MICRO_SHIFT_LO +: 3]),
    .y     (alu_y)
  );

  icv_row_buffer #(.W(PIX_W), .DEPTH(ROW_MAX)) u_row1 (
    .clk  (clk),
    .rst  (rst),
    .clr  (!frame_n),
    .en   (run),
    .len  (st.row_len),
    .din  (st.alu_q),
    .dout (row1_q)
  );

  icv_row_buffer #(.W(PIX_W), .DEPTH(ROW_MAX)) u_row2 (
    .clk  (clk),
    .rst  (rst),
    .clr  (!frame_n),
    .en   (run),
    .len  (st.row_len),
    .din  (row1_q),
    .dout (row2_q)
  );

  // External row buffers feed the upper two window rows in bypass mode.
  assign src1 = st.init[INIT_CASC_BIT] ? cascade_in[PIX_W-1:0] : row1_q;
  assign src2 = st.init[INIT_CASC_BIT] ? cascade_in[CAS_W-1:PIX_W] : row2_q;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic signed [RES_W-1:0] acc;
    logic [PIX_W:0]          px;
    logic [PIX_W:0]          cf;
    logic [1:0]              csh;
    logic [1:0]              rnd;
    acc     = '0;
    px      = '0;
    cf      = '0;
    csh     = st.init[INIT_CSH_LO +: 2];
    rnd     = st.init[INIT_RND_LO +: 2];
    next_st = st;

    // Control interface: the strobe is watched whatever hold does.
    next_st.ld_q   = load_strobe_n;
    next_st.hold_q = hold;
    if (st.row_state == ROW_OPEN) begin
      next_st.row_cnt = st.row_cnt + 1'b1;
    end
    case (st.row_state)
      ROW_OPEN: begin
        // Nothing written in time: the full length is locked in.
        if (st.row_cnt == 11'(ROW_LOAD_WINDOW - 1)) begin
          next_st.row_len   = ROWLEN_RESET;
          next_st.row_state = ROW_LOCKED;
        end
      end
      ROW_LOCKED: next_st.row_cnt = st.row_cnt;
      default:    next_st.row_state = ROW_LOCKED;
    endcase
    if (strobe_rise) begin
      case (reg_select)
        ADDR_MICRO:  next_st.micro = config_bus;
        ADDR_ROWLEN: begin
          // A written value wins over the timeout in the same cycle.
          if (st.row_state == ROW_OPEN) begin
            next_st.row_len   = config_bus;
            next_st.row_state = ROW_LOCKED;
          end
        end
        ADDR_BANK0: begin
          next_st.coef0[st.wptr0] = config_bus[PIX_W-1:0];
          next_st.wptr0 = (st.wptr0 == WPTR_LAST) ? '0 : st.wptr0 + 1'b1;
        end
        ADDR_BANK1: begin
          next_st.coef1[st.wptr1] = config_bus[PIX_W-1:0];
          next_st.wptr1 = (st.wptr1 == WPTR_LAST) ? '0 : st.wptr1 + 1'b1;
        end
        ADDR_INIT: next_st.init = config_bus[INIT_W-1:0];
        ADDR_USE0: next_st.bank_sel = 1'b0;
        ADDR_USE1: next_st.bank_sel = 1'b1;
        default:   next_st.bank_sel = st.bank_sel;
      endcase
    end

    // Data path: only moves while not held.
    if (run) begin
      if (operand_load_en) begin
        next_st.operand = config_bus[PIX_W-1:0];
      end
      next_st.dly[0] = pixel_in;
      for (int k = 1; k < DLY_MAX; k++) begin
        next_st.dly[k] = st.dly[k-1];
      end
      next_st.alu_q = alu_y;
      next_st.win[0][0] = st.alu_q;
      next_st.win[1][0] = src1;
      next_st.win[2][0] = src2;
      for (int r = 0; r < 3; r++) begin
        next_st.win[r][1] = st.win[r][0];
        next_st.win[r][2] = st.win[r][1];
      end
      // Nine multipliers, operands widened by one bit per chosen format.
      for (int r = 0; r < 3; r++) begin
        for (int c = 0; c < 3; c++) begin
          px = {st.init[INIT_PIXS_BIT] & st.win[r][c][PIX_W-1], st.win[r][c]};
          if (st.bank_sel) begin
            cf = {st.init[INIT_COEFS_BIT] & st.coef1[r*3+c][PIX_W-1], st.coef1[r*3+c]};
          end else begin
            cf = {st.init[INIT_COEFS_BIT] & st.coef0[r*3+c][PIX_W-1], st.coef0[r*3+c]};
          end
          next_st.prod[r*3+c] = PROD_W'($signed(px) * $signed(cf));
        end
      end
      // Sum of products plus the cascade term when chips are chained.
      for (int k = 0; k < TAPS; k++) begin
        acc = acc + RES_W'($signed(st.prod[k]));
      end
      if (!st.init[INIT_CASC_BIT]) begin
        acc = acc + (RES_W'($signed(cascade_in)) <<< {csh, 1'b0});
      end
      if (rnd == RND_16) begin
        acc = (acc + RND16_HALF) & RND16_MASK;
      end else if (rnd == RND_8) begin
        acc = (acc + RND8_HALF) & RND8_MASK;
      end
      next_st.result = acc;
    end

    // Frame start clears the data path only.
    if (!frame_n) begin
      next_st.dly    = '0;
      next_st.alu_q  = '0;
      next_st.win    = '0;
      next_st.prod   = '0;
      next_st.result = '0;
    end

    // Reset clears all state but the strobe sample, which is set high; the microcode takes its default pattern.
    if (rst) begin
      next_st         = '0;
      next_st.ld_q    = 1'b1;
      next_st.micro   = MICRO_RESET;
      next_st.row_len = ROWLEN_RESET;
      next_st.init    = INIT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign result_out  = st.result;
  // The enable follows its pin without a clock edge, as a bus driver must.
  assign result_oe_n = oe_n;
  // The second buffer's register already holds the twice-delayed stream.
  assign cascade_out = row2_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_reset_state;
    $fell(rst) |-> result_out == '0 && cascade_out == '0 && st.micro == MICRO_RESET
                   && st.bank_sel == 1'b0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_frame_clear;
    !frame_n |=> result_out == '0 && st.alu_q == '0;
  endproperty
  a_frame_clear: assert property (p_frame_clear) else $error("frame did not clear");

  property p_frame_keeps_cfg;
    !frame_n && !strobe_rise |=> $stable(st.micro) && $stable(st.init) && $stable(st.coef0);
  endproperty
  a_frame_keeps_cfg: assert property (p_frame_keeps_cfg) else $error("frame hit config");

  property p_operand_load;
    operand_load_en && !st.hold_q |=> st.operand == $past(config_bus[PIX_W-1:0]);
  endproperty
  a_operand_load: assert property (p_operand_load) else $error("operand not loaded");

  sequence s_hold_seen;
    hold ##1 hold;
  endsequence
  property p_hold_freeze;
    s_hold_seen ##0 frame_n |=> $stable(result_out) && $stable(st.alu_q);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("state moved in hold");

  property p_cs_blocks;
    cs_n |=> $stable(st.micro) && $stable(st.init) && $stable(st.bank_sel);
  endproperty
  a_cs_blocks: assert property (p_cs_blocks) else $error("load while deselected");

  sequence s_strobe_rise;
    !load_strobe_n && !cs_n ##1 load_strobe_n && !cs_n;
  endsequence
  property p_bank_one;
    s_strobe_rise ##0 reg_select == ADDR_USE1 |=> st.bank_sel == 1'b1;
  endproperty
  a_bank_one: assert property (p_bank_one) else $error("bank one not active");

  property p_bank_zero;
    s_strobe_rise ##0 reg_select == ADDR_USE0 |=> st.bank_sel == 1'b0;
  endproperty
  a_bank_zero: assert property (p_bank_zero) else $error("bank zero not active");

  property p_setup_load;
    s_strobe_rise ##0 reg_select == ADDR_INIT |=> st.init == $past(config_bus[INIT_W-1:0]);
  endproperty
  a_setup_load: assert property (p_setup_load) else $error("setup not loaded");

  property p_micro_load;
    s_strobe_rise ##0 reg_select == ADDR_MICRO |=> st.micro == $past(config_bus);
  endproperty
  a_micro_load: assert property (p_micro_load) else $error("microcode not loaded");

  property p_pixel_capture;
    !st.hold_q && frame_n |=> st.dly[0] == $past(pixel_in);
  endproperty
  a_pixel_capture: assert property (p_pixel_capture) else $error("pixel not captured");

  property p_row_once;
    st.row_state == ROW_LOCKED |=> $stable(st.row_len);
  endproperty
  a_row_once: assert property (p_row_once) else $error("row length rewritten");

  property p_coef_wrap;
    strobe_rise && reg_select == ADDR_BANK0 && st.wptr0 == WPTR_LAST |=> st.wptr0 == '0;
  endproperty
  a_coef_wrap: assert property (p_coef_wrap) else $error("bank pointer no wrap");

endmodule
`default_nettype wire

/* design/icv_pkg.sv */
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants of the 3x3 image convolver.
// ---------------------------------------------------------------------------
package icv_pkg;

  // Data path widths and sizes.
  localparam int PIX_W    = 8;
  localparam int CFG_W    = 10;
  localparam int INIT_W   = 9;
  localparam int RES_W    = 20;
  localparam int CAS_W    = 16;
  localparam int PROD_W   = 18;
  localparam int TAPS     = 9;
  localparam int DLY_MAX  = 4;
  localparam int ROW_MAX  = 1024;

  // Clocks allowed after reset for the one-time row length write.
  localparam int ROW_LOAD_WINDOW = 1024;

  // Configuration addresses on reg_select.
  localparam logic [2:0] ADDR_MICRO  = 3'h0;
  localparam logic [2:0] ADDR_ROWLEN = 3'h1;
  localparam logic [2:0] ADDR_BANK0  = 3'h2;
  localparam logic [2:0] ADDR_BANK1  = 3'h3;
  localparam logic [2:0] ADDR_INIT   = 3'h4;
  localparam logic [2:0] ADDR_USE0   = 3'h5;
  localparam logic [2:0] ADDR_USE1   = 3'h6;

  // Reset values of the control registers.
  localparam logic [CFG_W-1:0]  MICRO_RESET  = 10'h018;
  localparam logic [CFG_W-1:0]  ROWLEN_RESET = 10'h000;
  localparam logic [INIT_W-1:0] INIT_RESET   = 9'h000;

  // Field positions of setup_config.
  localparam int INIT_CASC_BIT  = 0;
  localparam int INIT_DLY_LO    = 1;
  localparam int INIT_PIXS_BIT  = 3;
  localparam int INIT_COEFS_BIT = 4;
  localparam int INIT_RND_LO    = 5;
  localparam int INIT_CSH_LO    = 7;

  // Field positions of point_op_microcode.
  localparam int MICRO_SHIFT_LO = 7;
  localparam int MICRO_OP_W     = 7;

  // Rounding codes, their half-LSB addends and keep masks.
  localparam logic [1:0]       RND_16      = 2'h1;
  localparam logic [1:0]       RND_8       = 2'h2;
  localparam logic [RES_W-1:0] RND16_HALF  = 20'h00008;
  localparam logic [RES_W-1:0] RND16_MASK  = 20'hffff0;
  localparam logic [RES_W-1:0] RND8_HALF   = 20'h00800;
  localparam logic [RES_W-1:0] RND8_MASK   = 20'hff000;

  // Last index of a coefficient bank write pointer.
  localparam logic [3:0] WPTR_LAST = 4'h8;

  // Row length loader states.
  typedef enum logic {ROW_OPEN, ROW_LOCKED} icv_row_state_t;

endpackage
`default_nettype wire

/* design/icv_point_alu.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Point-operation ALU with shifter on the pixel path.
// ---------------------------------------------------------------------------
module icv_point_alu (
  input  wire logic [icv_pkg::PIX_W-1:0]      a,
  input  wire logic [icv_pkg::PIX_W-1:0]      b,
  input  wire logic [icv_pkg::MICRO_OP_W-1:0] op,
  input  wire logic [2:0]                     shift,
  output logic      [icv_pkg::PIX_W-1:0]      y
);
  import icv_pkg::*;

  // Logical codes are a truth table: bit 6 for a=0,b=0 up to bit 3 for
  // a=1,b=1. Arithmetic is keyed by the low three bits.
  always_comb begin
    logic [9:0] raw;
    logic [9:0] shifted;
    raw     = '0;
    shifted = '0;
    case (op[2:0])
      3'h1: raw = {2'h0, a} + {2'h0, b};
      3'h2: raw = {2'h0, a} - {2'h0, b};
      3'h4: raw = {2'h0, b} - {2'h0, a};
      default: begin
        raw = {2'h0, ({PIX_W{op[6]}} & ~a & ~b) | ({PIX_W{op[5]}} & ~a & b)
                   | ({PIX_W{op[4]}} & a & ~b) | ({PIX_W{op[3]}} & a & b)};
      end
    endcase
    // The shift acts on the wide result so a right shift keeps the carry.
    case (shift)
      3'h1: shifted = raw >> 1;
      3'h2: shifted = raw >> 2;
      3'h3: shifted = raw >> 3;
      3'h4: shifted = raw << 1;
      3'h5: shifted = raw << 2;
      3'h6: shifted = raw << 3;
      default: shifted = raw;
    endcase
    y = shifted[PIX_W-1:0];
  end

endmodule
`default_nettype wire

/* design/icv_row_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Programmable row delay built as a circular buffer.
// ---------------------------------------------------------------------------
module icv_row_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 1024,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          clr,
  input  wire logic          en,
  input  wire logic [AW-1:0] len,
  input  wire logic [W-1:0]  din,
  output logic      [W-1:0]  dout
);
  typedef struct packed {
    logic [AW-1:0] ptr;
    logic [AW:0]   fill;
    logic [W-1:0]  dout;
  } icv_rb_state_t;

  icv_rb_state_t st;
  icv_rb_state_t next_st;
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] last;
  logic [AW:0]   span;

  // The output register is the last stage, so the ring holds one word less
  // than the row; a length of zero stands for the full depth.
  assign last = (len == '0) ? AW'(DEPTH - 2) : len - 2'd2;
  assign span = (len == '0) ? (AW + 1)'(DEPTH - 1) : {1'b0, len} - 1'b1;

  // Storage is not cleared by a frame start; the fill count masks stale
  // words until a whole row of fresh samples has gone in.
  always_comb begin
    next_st = st;
    if (rst || clr) begin
      next_st = '0;
    end else if (en) begin
      if (span == '0) begin
        // A one-stage row is the output register alone.
        next_st.dout = din;
      end else begin
        next_st.dout = (st.fill >= span) ? mem[st.ptr] : '0;
        next_st.ptr  = (st.ptr >= last) ? '0 : st.ptr + 1'b1;
        if (st.fill < span) begin
          next_st.fill = st.fill + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Sample store, written at the read pointer after the old word is read.
  always_ff @(posedge clk) begin
    if (en && !clr && !rst) begin
      mem[st.ptr] <= din;
    end
  end

  assign dout = st.dout;

  property p_ptr_wrap;
    @(posedge clk) disable iff (rst || clr)
      en && span != '0 && st.ptr == last |=> st.ptr == '0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("row pointer did not wrap");

endmodule
`default_nettype wire
